// File: include/iprt_pkg.sv
// Behaviour
// - each event source has one routing bit, 0 sends it to the first pin, 1 to the second, and only when enabled, except boot with the boot strap high.
// - routing bits are 7 ready, 6 buffer, 5 outside, 4 within, 3 orientation, 2 autosleep, 1 boot, 0 wake state.
// - the buffer source is the OR of the overflow, watermark and gate error flags.
// - while the second pin is the trigger input and the boot strap is low, a routing bit of 1 is ignored and nothing drives that pin.
// - with the boot strap high only boot may reach the second pin, other sources routed there reach no pin.
// - with the boot strap high the boot routing bit is ignored and boot is fixed to the second pin.
// - the boot routing bit keeps its value through a soft reset and is lost only on power-on reset.
// - bit 0 selects which pin carries the wake state level, 0 first pin, 1 second pin.
// - all eight routing bits reset to 0 and are read/write.
// - with the strap low and boot enabled, the selected pin pulses on boot completion with the set polarity.
// - with wake output enabled, the pin is active while system mode is 01b and inactive otherwise.
package iprt_pkg;
  // ------------------------------------------------------------
  // register map: index, byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [7:0] ROUTE_IDX = 8'h21;
  localparam logic [7:0] ENABLE_IDX = 8'h20;
  localparam logic [7:0] CONFIG_IDX = 8'h30;
  localparam logic [7:0] STATUS_IDX = 8'h31;
  localparam logic [7:0] MASK_IDX = 8'h32;
  localparam logic [7:0] PINS_IDX = 8'h33;
  // ------------------------------------------------------------
  // source bit positions
  // ------------------------------------------------------------
  localparam int SRC_READY = 7;
  localparam int SRC_BUFFER = 6;
  localparam int SRC_OUTSIDE = 5;
  localparam int SRC_WITHIN = 4;
  localparam int SRC_ORIENT = 3;
  localparam int SRC_SLEEP = 2;
  localparam int BOOT_COMPLETE_EVENT = 1;
  localparam int SRC_WAKE = 0;
  // ------------------------------------------------------------
  // config fields and reset values
  // ------------------------------------------------------------
  localparam int CFG_POL = 0;
  localparam int CFG_TRIG = 1;
  localparam int CFG_SOFT = 7;
  localparam logic [7:0] ROUTE_RST = 8'h00;
  localparam logic [7:0] ENABLE_RST = 8'h02;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [1:0] WAKE_MODE = 2'h1;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int BOOT1_US = 1;
  localparam int BOOT2_MS = 1;
  localparam int BOOT1_CYC = BOOT1_US * CLK_MHZ;
  localparam int BOOT2_CYC = BOOT2_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 16;
  typedef enum logic [1:0] {
    IPRT_IDLE = 2'b00,
    IPRT_DATA = 2'b01,
    IPRT_DONE = 2'b10
  } iprt_bus_t;
endpackage

// File: design/iprt_router.sv
module iprt_router #(
  parameter int BOOT2_CYC = iprt_pkg::BOOT2_CYC
) (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  // ahb-lite slave
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic O_HREADYOUT,
  output logic [31:0] O_HRDATA,
  output logic O_HRESP,
  // event sources
  input wire logic I_READY,
  input wire logic I_BUFFER_OVERFLOW_FLAG,
  input wire logic I_BUFFER_WATERMARK_FLAG,
  input wire logic I_BUFFER_GATE_ERROR,
  input wire logic I_OUTSIDE_THRESH,
  input wire logic I_WITHIN_THRESH,
  input wire logic I_ORIENTATION,
  input wire logic I_AUTOSLEEP,
  input wire logic I_BOOT_COMPLETE_EVENT,
  input wire logic [1:0] I_SYS_MODE,
  input wire logic I_BOOT_STRAP_PIN,
  // pins and interrupt
  output logic O_FIRST_IRQ_PIN,
  output logic O_SECOND_IRQ_PIN,
  output logic O_SECOND_IRQ_PIN_OE,
  output logic O_IRQ
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] route;
  logic [7:0] enable;
  logic [7:0] config_q;
  logic [7:0] status;
  logic [7:0] mask;
  logic [7:0] src_prev;
  logic strap;
  logic strap_taken;
  logic soft_rst;
  logic [iprt_pkg::CNT_W-1:0] boot_cnt;
  logic boot_fixed;
  iprt_pkg::iprt_bus_t bus_state;
  logic [7:0] bus_idx;
  logic bus_wr;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  wire addr_take = I_HSEL & I_HREADY & I_HTRANS[1];
  wire do_wr = (bus_state == iprt_pkg::IPRT_DATA) & bus_wr;
  wire do_rd = (bus_state == iprt_pkg::IPRT_DATA) & ~bus_wr;
  wire wr_route = do_wr & (bus_idx == iprt_pkg::ROUTE_IDX);
  wire wr_enable = do_wr & (bus_idx == iprt_pkg::ENABLE_IDX);
  wire wr_config = do_wr & (bus_idx == iprt_pkg::CONFIG_IDX);
  wire wr_mask = do_wr & (bus_idx == iprt_pkg::MASK_IDX);
  wire rd_status = do_rd & (bus_idx == iprt_pkg::STATUS_IDX);
  wire [7:0] wdata = I_HWDATA[7:0];

  // read mux; unmapped words read zero
  logic [7:0] rd_mux;
  always_comb begin
    case (bus_idx)
      iprt_pkg::ROUTE_IDX: rd_mux = route;
      iprt_pkg::ENABLE_IDX: rd_mux = enable;
      iprt_pkg::CONFIG_IDX: rd_mux = {1'b0, config_q[6:0]};
      iprt_pkg::STATUS_IDX: rd_mux = status;
      iprt_pkg::MASK_IDX: rd_mux = mask;
      iprt_pkg::PINS_IDX: rd_mux = {5'h00, strap, O_SECOND_IRQ_PIN, O_FIRST_IRQ_PIN};
      default: rd_mux = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // sources
  // ------------------------------------------------------------
  wire pol = config_q[iprt_pkg::CFG_POL];
  wire trig_fn = config_q[iprt_pkg::CFG_TRIG];
  wire buf_any = I_BUFFER_OVERFLOW_FLAG | I_BUFFER_WATERMARK_FLAG
               | I_BUFFER_GATE_ERROR;
  wire boot_pulse = (boot_cnt != '0) & ~boot_fixed;
  wire wake_lvl = (I_SYS_MODE == iprt_pkg::WAKE_MODE);
  wire [7:0] src_raw = {I_READY, buf_any, I_OUTSIDE_THRESH, I_WITHIN_THRESH,
                        I_ORIENTATION, I_AUTOSLEEP, boot_pulse, wake_lvl};
  wire [7:0] src = src_raw & enable;
  wire [7:0] to_first;
  wire [7:0] to_second;

  // per-source steering; strap and trigger function override routing
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_route
      if (g == iprt_pkg::BOOT_COMPLETE_EVENT) begin : g_boot
        // strap high: boot never takes the routed path, handled as fixed pulse
        assign to_first[g] = ~strap & (~route[g] | trig_fn);
        assign to_second[g] = ~strap & route[g] & ~trig_fn;
      end else begin : g_other
        // a 1 under trigger function with strap low falls back to the first pin
        assign to_first[g] = ~route[g] | (trig_fn & ~strap);
        assign to_second[g] = route[g] & ~trig_fn & ~strap;
      end
    end
  endgenerate

  wire act_first = |(src & to_first);
  wire act_second = |(src & to_second);
  wire fixed_low = boot_fixed & (boot_cnt != '0);
  wire next_first = pol ? act_first : ~act_first;
  wire next_second = fixed_low ? 1'b0 : (pol ? act_second : ~act_second);
  wire next_oe = ~trig_fn | strap;
  wire [7:0] src_rise = src & ~src_prev;
  wire [7:0] next_status = (status & ~(rd_status ? 8'hff : 8'h00)) | src_rise;
  wire next_irq = |(next_status & mask);

  // boot pulse counter, loaded from the strap-dependent length
  wire boot_start = I_BOOT_COMPLETE_EVENT & (strap | enable[iprt_pkg::BOOT_COMPLETE_EVENT]);
  wire [iprt_pkg::CNT_W-1:0] boot_len = strap ? BOOT2_CYC[iprt_pkg::CNT_W-1:0]
                                              : iprt_pkg::BOOT1_CYC[iprt_pkg::CNT_W-1:0];

  // ------------------------------------------------------------
  // bus sequencing: one wait state per transfer
  // ------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      bus_state <= iprt_pkg::IPRT_IDLE;
      bus_idx <= 8'h00;
      bus_wr <= 1'b0;
      O_HREADYOUT <= 1'b1;
      O_HRDATA <= 32'h0000_0000;
      O_HRESP <= 1'b0;
    end else begin
      O_HRESP <= 1'b0;
      case (bus_state)
        iprt_pkg::IPRT_IDLE: begin
          if (addr_take) begin
            bus_state <= iprt_pkg::IPRT_DATA;
            bus_idx <= I_HADDR[9:2];
            bus_wr <= I_HWRITE;
            O_HREADYOUT <= 1'b0;
          end
        end
        iprt_pkg::IPRT_DATA: begin
          // reads sample here so a preceding write is already visible
          O_HRDATA <= {24'h00_0000, do_rd ? rd_mux : 8'h00};
          O_HREADYOUT <= 1'b1;
          bus_state <= iprt_pkg::IPRT_DONE;
        end
        iprt_pkg::IPRT_DONE: begin
          bus_state <= iprt_pkg::IPRT_IDLE;
          if (addr_take) begin
            bus_state <= iprt_pkg::IPRT_DATA;
            bus_idx <= I_HADDR[9:2];
            bus_wr <= I_HWRITE;
            O_HREADYOUT <= 1'b0;
          end
        end
        default: bus_state <= iprt_pkg::IPRT_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // routing register: boot bit survives soft reset
  // ------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      route <= iprt_pkg::ROUTE_RST;
    end else if (wr_route) begin
      route <= wdata;
    end else if (soft_rst) begin
      route <= (iprt_pkg::ROUTE_RST & 8'hfd) | (route & 8'h02);
    end
  end

  // other software registers, all returned to their reset values by soft reset
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N || soft_rst) begin
      enable <= iprt_pkg::ENABLE_RST;
      config_q <= iprt_pkg::CONFIG_RST;
      mask <= iprt_pkg::MASK_RST;
    end else begin
      if (wr_enable) enable <= wdata;
      if (wr_config) config_q <= wdata;
      if (wr_mask) mask <= wdata;
    end
  end

  // soft reset is a one-cycle pulse after writing the command bit
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= wr_config & wdata[iprt_pkg::CFG_SOFT];
    end
  end

  // strap caught once, on the first edge after power-on release
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      strap <= 1'b0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      strap <= I_BOOT_STRAP_PIN;
      strap_taken <= 1'b1;
    end
  end

  // boot pulse timer; a new completion restarts it
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      boot_cnt <= '0;
      boot_fixed <= 1'b0;
    end else if (boot_start) begin
      boot_cnt <= boot_len;
      boot_fixed <= strap;
    end else if (boot_cnt != '0) begin
      boot_cnt <= boot_cnt - 1'b1;
    end
  end

  // ------------------------------------------------------------
  // status, interrupt and pins, all registered
  // ------------------------------------------------------------
  // a new rising edge in the read-clear cycle is kept
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N || soft_rst) begin
      status <= 8'h00;
      src_prev <= 8'h00;
      O_IRQ <= 1'b0;
    end else begin
      status <= next_status;
      src_prev <= src;
      O_IRQ <= next_irq;
    end
  end

  // pins idle inactive: polarity 0 means active low, so idle high
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      O_FIRST_IRQ_PIN <= 1'b1;
      O_SECOND_IRQ_PIN <= 1'b1;
      O_SECOND_IRQ_PIN_OE <= 1'b0;
    end else begin
      O_FIRST_IRQ_PIN <= next_first;
      O_SECOND_IRQ_PIN <= next_second;
      O_SECOND_IRQ_PIN_OE <= next_oe;
    end
  end
endmodule

// File: test/iprt_checker.sv
module iprt_checker (
  // watched ports of the router
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  input wire logic I_HSEL,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HREADY,
  input wire logic I_BOOT_COMPLETE_EVENT,
  input wire logic I_BOOT_STRAP_PIN,
  input wire logic O_HREADYOUT,
  input wire logic [31:0] O_HRDATA,
  input wire logic O_HRESP,
  input wire logic O_SECOND_IRQ_PIN,
  input wire logic O_SECOND_IRQ_PIN_OE,
  input wire logic O_IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------
  // bus and pin properties
  // --------
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESET_N);
  // a transfer is taken only while the bus is ready
  wire logic taken = I_HSEL && I_HREADY && I_HTRANS[1];
  sequence one_wait;
    !O_HREADYOUT ##1 O_HREADYOUT;
  endsequence
  // a strapped boot holds the second pin low and driven
  sequence boot_hold;
    (!O_SECOND_IRQ_PIN && O_SECOND_IRQ_PIN_OE) [*8];
  endsequence
  wait_state_a: assert property (taken && O_HREADYOUT |=> one_wait)
    else $error("bus wait state not one cycle");
  idle_ready_a: assert property (O_HREADYOUT && !taken |=> O_HREADYOUT)
    else $error("ready dropped with no transfer");
  resp_okay_a: assert property (O_HRESP == 1'h0)
    else $error("error response seen");
  upper_zero_a: assert property (O_HRDATA[31:8] == 24'h0)
    else $error("upper read data not zero");
  reset_state_a: assert property ($rose(I_RESET_N) |-> !O_SECOND_IRQ_PIN_OE && !O_IRQ)
    else $error("pin enable or irq set after reset");
  reset_data_a: assert property ($rose(I_RESET_N) |-> O_HRDATA == 32'h0 && O_HREADYOUT)
    else $error("bus outputs wrong after reset");
  // counter loads one edge after the event, the registered pin follows one edge later
  strap_boot_a: assert property (I_BOOT_STRAP_PIN && I_BOOT_COMPLETE_EVENT |=> ##1 boot_hold)
    else $error("strapped boot pulse missing");
  strap_oe_a: assert property (I_BOOT_STRAP_PIN && $past(I_RESET_N, 2) && $past(I_RESET_N)
    |-> O_SECOND_IRQ_PIN_OE) else $error("strapped second pin not driven");
endmodule
bind iprt_router iprt_checker u_chk (.I_REF_CLK, .I_RESET_N, .I_HSEL, .I_HTRANS, .I_HREADY,
  .I_BOOT_COMPLETE_EVENT, .I_BOOT_STRAP_PIN, .O_HREADYOUT, .O_HRDATA, .O_HRESP,
  .O_SECOND_IRQ_PIN, .O_SECOND_IRQ_PIN_OE, .O_IRQ);

// File: test/iprt_host_model.sv
module iprt_host_model (
  // pins from the device
  input wire logic i_first_pin,
  input wire logic i_second_pin,
  input wire logic i_second_oe,
  // levels the host sees
  output logic o_first_level,
  output logic o_second_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released second pin floats up to the board pull-up
  assign o_first_level = i_first_pin;
  assign o_second_level = i_second_oe ? i_second_pin : 1'h1;
endmodule

// File: test/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // --------
  // stimulus and observation
  // --------
  localparam int BOOT2_SIM = 40;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic strap = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready, hresp, pin1, pin2, oe, irq, lvl1, lvl2;
  logic [9:0] src = 10'h0; // bits 8 and 9 are extra buffer flags
  int fails = 0;
  int tests_run = 0;
  // free running clock
  always #20 clk = ~clk;
  iprt_router #(.BOOT2_CYC(BOOT2_SIM)) DUT (
    .I_REF_CLK(clk), .I_RESET_N(rst_n), .I_HSEL(1'h1), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
    .I_HREADY(hready), .O_HREADYOUT(hready), .O_HRDATA(hrdata), .O_HRESP(hresp),
    .I_READY(src[7]), .I_BUFFER_OVERFLOW_FLAG(src[6]), .I_BUFFER_WATERMARK_FLAG(src[8]),
    .I_BUFFER_GATE_ERROR(src[9]), .I_OUTSIDE_THRESH(src[5]), .I_WITHIN_THRESH(src[4]),
    .I_ORIENTATION(src[3]), .I_AUTOSLEEP(src[2]), .I_BOOT_COMPLETE_EVENT(src[1]),
    .I_SYS_MODE({1'h0, src[0]}), .I_BOOT_STRAP_PIN(strap), .O_FIRST_IRQ_PIN(pin1),
    .O_SECOND_IRQ_PIN(pin2), .O_SECOND_IRQ_PIN_OE(oe), .O_IRQ(irq));
  iprt_host_model host (.i_first_pin(pin1), .i_second_pin(pin2), .i_second_oe(oe),
    .o_first_level(lvl1), .o_second_level(lvl2));
  // verdict, the single exit of the run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one single ahb transfer, bounded waits on hready
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    htrans <= 2'h2;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= w;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'h1 && n < 20);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'h1 && n < 40);
    rd = hrdata;
    if (hready !== 1'h1) begin
      fails++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(1'h1, idx, d, x);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] e);
    logic [31:0] x;
    bus(1'h0, idx, 32'h0, x);
    check(x, e);
  endtask
  // pins answer one cycle after a source moves
  task automatic pins(input logic e1, input logic e2);
    repeat (2) @(posedge clk);
    check({30'h0, lvl1, lvl2}, {30'h0, e1, e2});
  endtask
  // width of the next pulse on the second pin, first pin held idle meanwhile
  task automatic width(input logic lv, input int exp);
    int w;
    int n;
    w = 0;
    n = 0;
    while (lvl2 !== lv && n < 20) begin
      @(posedge clk);
      n++;
    end
    while (lvl2 === lv && w < 200) begin
      check({31'h0, lvl1}, {31'h0, ~lv});
      @(posedge clk);
      w++;
    end
    check(w, exp);
  endtask
  // reset values, read/write and an unmapped place
  task automatic t_regs();
    rdc(iprt_pkg::ROUTE_IDX, 32'h0);
    rdc(iprt_pkg::ENABLE_IDX, {24'h0, iprt_pkg::ENABLE_RST});
    wr(iprt_pkg::ROUTE_IDX, 32'ha5);
    rdc(iprt_pkg::ROUTE_IDX, 32'ha5);
    wr(8'h3f, 32'hff);
    rdc(8'h3f, 32'h0);
    pins(1'h1, 1'h1);
    $display("test regs done");
  endtask
  // every source except boot to each pin, then status, mask and irq
  task automatic t_route();
    wr(iprt_pkg::CONFIG_IDX, 32'h1);
    wr(iprt_pkg::ENABLE_IDX, 32'hff);
    for (int r = 0; r < 2; r++) begin
      wr(iprt_pkg::ROUTE_IDX, r ? 32'hff : 32'h0);
      for (int b = 0; b < 10; b++) begin
        if (b != 1) begin
          src[b] <= 1'h1;
          pins(r == 0, r == 1);
          src[b] <= 1'h0;
          pins(1'h0, 1'h0);
        end
      end
    end
    rdc(iprt_pkg::STATUS_IDX, 32'hfd);
    wr(iprt_pkg::MASK_IDX, 32'h80);
    src[7] <= 1'h1;
    pins(1'h0, 1'h1);
    check({31'h0, irq}, 32'h1);
    rdc(iprt_pkg::STATUS_IDX, 32'h80);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    src[7] <= 1'h0;
    wr(iprt_pkg::MASK_IDX, 32'h0);
    src[7] <= 1'h1;
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    src[7] <= 1'h0;
    $display("test route done");
  endtask
  // second pin as trigger input: routing to it ignored, pin released
  task automatic t_trig();
    wr(iprt_pkg::CONFIG_IDX, 32'h3);
    src[7] <= 1'h1;
    pins(1'h1, 1'h1);
    check({31'h0, oe}, 32'h0);
    src[7] <= 1'h0;
    wr(iprt_pkg::CONFIG_IDX, 32'h1);
    $display("test trigger done");
  endtask
  // boot pulse width, then soft reset keeps the boot routing bit
  task automatic t_boot();
    wr(iprt_pkg::ROUTE_IDX, 32'h2);
    src[1] <= 1'h1;
    @(posedge clk);
    src[1] <= 1'h0;
    width(1'h1, iprt_pkg::BOOT1_CYC);
    wr(iprt_pkg::ROUTE_IDX, 32'h3);
    wr(iprt_pkg::CONFIG_IDX, 32'h80);
    repeat (2) @(posedge clk);
    rdc(iprt_pkg::ROUTE_IDX, 32'h2);
    rdc(iprt_pkg::ENABLE_IDX, {24'h0, iprt_pkg::ENABLE_RST});
    $display("test boot done");
  endtask
  // strap high: sources routed high vanish, boot fixed to second pin
  task automatic t_strap();
    rst_n <= 1'h0;
    strap <= 1'h1;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    wr(iprt_pkg::ENABLE_IDX, 32'hff);
    wr(iprt_pkg::ROUTE_IDX, 32'hfd);
    src[7] <= 1'h1;
    pins(1'h1, 1'h1);
    src[7] <= 1'h0;
    src[1] <= 1'h1;
    @(posedge clk);
    src[1] <= 1'h0;
    width(1'h0, BOOT2_SIM);
    rdc(iprt_pkg::PINS_IDX, 32'h7);
    $display("test strap done");
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    t_regs();
    t_route();
    t_trig();
    t_boot();
    t_strap();
    tally_and_finish();
  end
endmodule
